/* sim/target_feed.sv */
// target readout front end model: marks and detected values
`timescale 1ns/1ns
module target_feed (
  // clock
  input  wire       i_clk,
  // readout stream
  input  wire       i_fe_ready,
  output reg        o_fe_valid,
  output reg        o_fe_mark,
  output reg  [8:0] o_fe_data
);
  int stalls = 0;
  initial begin
    o_fe_valid = 1'b0;
    o_fe_mark = 1'b0;
    o_fe_data = 9'h000;
  end
  // released lines show inverted data so stale values never look valid
  task automatic idle;
    @(negedge i_clk);
    o_fe_valid = 1'b0;
    o_fe_data = ~o_fe_data;
  endtask
  // one word, held until taken; gap models a slow front end
  task automatic send(input logic m, input logic [8:0] d, input int gap);
    int n;
    if (gap > 0) idle;
    repeat (gap) @(negedge i_clk);
    @(negedge i_clk);
    o_fe_valid = 1'b1;
    o_fe_mark = m;
    o_fe_data = d;
    for (n = 0; n < 3000 && i_fe_ready !== 1'b1; n++) @(negedge i_clk);
    if (n == 3000) begin
      stalls++;
      $display("Error fe_ready expected 1 seen stall");
    end
    @(posedge i_clk);
  endtask
endmodule

/* sim/wave_store_chk.sv */
// assertion checker for the waveform capture store ports
`timescale 1ns/1ns
`include "wave_store_consts.vh"
module wave_store_chk (
  // clock and reset
  input wire        i_clk,
  input wire        i_nrst,
  // control and read port
  input wire        i_start,
  input wire        i_rd_req,
  input wire [2:0]  i_rd_cmd,
  input wire        o_rd_valid,
  input wire [15:0] o_rd_data,
  // status
  input wire        o_fe_ready,
  input wire        o_busy,
  input wire        o_done,
  input wire [10:0] o_raw_count
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_dump;
    i_rd_req && i_rd_cmd == `CMD_DUMP;
  endsequence
  sequence s_unwrap;
    i_rd_req && i_rd_cmd == `CMD_READ_Y;
  endsequence
  a_read_answer: assert property (i_rd_req |=> o_rd_valid) else $error("read not answered");
  a_valid_single: assert property (!i_rd_req |=> !o_rd_valid) else $error("stray read valid");
  a_data_hold: assert property (!i_rd_req |=> $stable(o_rd_data)) else $error("read data moved");
  a_dump_word: assert property (s_dump |=> o_rd_data[15:11] == 5'h00 && !o_rd_data[9])
    else $error("raw word format");
  a_unwrap_word: assert property (s_unwrap |=> o_rd_data[15:11] == 5'h00 && !o_rd_data[9])
    else $error("unwrapped word format");
  a_bad_cmd: assert property (i_rd_req && i_rd_cmd > `CMD_DFL |=> o_rd_data == 16'h0000)
    else $error("unknown command data");
  a_done_pulse: assert property (o_done |=> !o_done && !o_busy) else $error("done not a pulse");
  a_start_busy: assert property (i_start && !o_busy && !o_done |=> o_busy) else $error("start ignored");
  a_raw_limit: assert property (o_raw_count <= 11'h400) else $error("raw count too big");
  a_reset_idle: assert property (disable iff (1'b0) !i_nrst |=> !o_busy && !o_done && !o_rd_valid && !o_fe_ready)
    else $error("reset state wrong");
endmodule
bind waveform_capture_store wave_store_chk u_chk (.i_clk, .i_nrst, .i_start, .i_rd_req, .i_rd_cmd, .o_rd_valid,
  .o_rd_data, .o_fe_ready, .o_busy, .o_done, .o_raw_count);

/* sim/waveform_capture_store_bench.sv */
// self-checking bench for the waveform capture store
`timescale 1ns/1ns
`include "wave_store_consts.vh"
module waveform_capture_store_bench;
  logic i_clk = 0, i_nrst = 0, i_start = 0, i_fast = 0, i_defect_en = 0, i_avg_mode = 0;
  logic i_avg_restart = 0, i_dfl_clear = 0, i_dfl_wr = 0, i_rd_req = 0;
  logic [9:0] i_dfl_data = 0, i_rd_addr = 0;
  logic [2:0] i_rd_cmd = 0;
  wire fe_valid, fe_mark, fe_ready, rd_valid, busy, done;
  wire [8:0] fe_data;
  wire [15:0] rd_data;
  wire [10:0] raw_count;
  int err_total = 0, samples_checked = 0;
  logic [28:0] r [0:23];
  always #25 i_clk = ~i_clk;
  waveform_capture_store u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_start(i_start), .i_fast(i_fast),
    .i_defect_en(i_defect_en), .i_avg_mode(i_avg_mode), .i_avg_restart(i_avg_restart), .i_fe_valid(fe_valid),
    .i_fe_mark(fe_mark), .i_fe_data(fe_data), .o_fe_ready(fe_ready), .i_dfl_clear(i_dfl_clear),
    .i_dfl_wr(i_dfl_wr), .i_dfl_data(i_dfl_data), .i_rd_req(i_rd_req), .i_rd_cmd(i_rd_cmd),
    .i_rd_addr(i_rd_addr), .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_busy(busy), .o_done(done),
    .o_raw_count(raw_count));
  target_feed u_feed (.i_clk(i_clk), .i_fe_ready(fe_ready), .o_fe_valid(fe_valid), .o_fe_mark(fe_mark),
    .o_fe_data(fe_data));
  task wrap_up;
    err_total += u_feed.stalls;
    $display("compared %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task check16(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task rd(input logic [28:0] row);
    @(negedge i_clk);
    i_rd_req = 1;
    {i_rd_cmd, i_rd_addr} = row[28:16];
    @(negedge i_clk);
    i_rd_req = 0;
    check16("rd_valid", 16'h0001, {15'h0000, rd_valid});
    check16("rd_data", row[15:0], rd_data);
  endtask
  task dfl(input logic [9:0] d);
    @(negedge i_clk);
    i_dfl_wr = 1;
    i_dfl_data = d;
    @(negedge i_clk);
    i_dfl_wr = 0;
  endtask
  // start, then wait a bounded time for the end-of-processing pulse
  task run;
    int n;
    @(negedge i_clk);
    i_start = 1;
    @(negedge i_clk);
    i_start = 0;
    for (n = 0; n < 4000 && done !== 1'b1; n++) @(negedge i_clk);
    if (n == 4000) begin
      err_total++;
      $display("Error done expected 1 seen timeout");
      wrap_up;
    end
  endtask
  initial begin
    r[0] = {3'h1, 10'h000, 16'h01FA};
    r[1] = {3'h1, 10'h002, 16'h0537};
    r[2] = {3'h0, 10'h000, 16'h019B};
    r[3] = {3'h0, 10'h001, 16'h0537};
    r[4] = {3'h0, 10'h020, 16'h01FA};
    r[5] = {3'h0, 10'h021, 16'h0000};
    r[6] = {3'h3, 10'h003, 16'h0002};
    r[7] = {3'h3, 10'h0C8, 16'h001E};
    r[8] = {3'h3, 10'h1FF, 16'h0001};
    r[9] = {3'h2, 10'h004, 16'h0002};
    r[10] = {3'h2, 10'h0C9, 16'h0020};
    r[11] = {3'h5, 10'h00F, 16'h0203};
    r[12] = {3'h5, 10'h00E, 16'h0137};
    r[13] = {3'h4, 10'h0C8, 16'h01FF};
    r[14] = {3'h4, 10'h2C8, 16'h01E2};
    r[15] = {3'h4, 10'h000, 16'h0000};
    r[16] = {3'h7, 10'h000, 16'h0000};
    r[17] = {3'h3, 10'h002, 16'h000E};
    r[18] = {3'h3, 10'h005, 16'h0000};
    r[19] = {3'h3, 10'h004, 16'h0002};
    r[20] = {3'h1, 10'h00E, 16'h01EA};
    r[21] = {3'h4, 10'h004, 16'h01C2};
    r[22] = {3'h4, 10'h204, 16'h01C2};
    r[23] = {3'h0, 10'h000, 16'h01FE};
    repeat (3) @(negedge i_clk);
    i_nrst = 1;
    check16("raw_count", 16'h0000, {5'h00, raw_count});
    @(negedge i_clk);
    i_dfl_clear = 1;
    @(negedge i_clk);
    i_dfl_clear = 0;
    dfl(10'h203);
    dfl(10'h137);
    i_defect_en = 1;
    // capture begins mid-target at scan 510; idle fill proves the buffer refuses
    fork
      begin
        for (int k = 0; k <= 512; k++) begin
          u_feed.send(1, 9'((510 + k) % 512), 0);
          if ((510 + k) % 512 == 3) begin
            u_feed.send(0, 9'h064, 2);
            u_feed.send(0, 9'h0C8, 0);
          end
          if ((510 + k) % 512 == 200) for (int y = 0; y <= 30; y++) u_feed.send(0, 9'(y), 0);
          if (k == 1) u_feed.send(0, 9'h005, 0);
        end
        u_feed.idle;
      end
      begin
        repeat (5) @(negedge i_clk);
        check16("fe_ready", 16'h0000, {15'h0000, fe_ready});
        run;
      end
    join
    check16("raw_count", 16'h0021, {5'h00, raw_count});
    for (int i = 0; i < 17; i++) rd(r[i]);
    i_fast = 1;
    i_avg_mode = 1;
    i_avg_restart = 1;
    fork
      begin
        for (int k = 0; k <= 256; k++) begin
          u_feed.send(1, 9'(k % 256), 0);
          if (k == 1) for (int y = 0; y < 15; y++) u_feed.send(0, 9'(y), 0);
          if (k == 2) begin
            u_feed.send(0, 9'h00A, 0);
            u_feed.send(0, 9'h032, 1);
          end
        end
        u_feed.idle;
      end
      run;
    join
    check16("raw_count", 16'h0010, {5'h00, raw_count});
    for (int i = 17; i < 24; i++) rd(r[i]);
    // cut frame: the front end stops after two scan starts and one value
    i_fast = 0;
    i_avg_mode = 0;
    i_avg_restart = 0;
    fork
      begin
        u_feed.send(1, 9'h007, 0);
        u_feed.send(0, 9'h010, 0);
        u_feed.send(1, 9'h008, 0);
        u_feed.idle;
      end
      run;
    join
    check16("busy", 16'h0000, {15'h0000, busy});
    check16("raw_count", 16'h0001, {5'h00, raw_count});
    rd({3'h0, 10'h000, 16'h01EF});
    rd({3'h3, 10'h007, 16'h0001});
    wrap_up;
  end
endmodule

/* verilog/wave_store_consts.vh */
// constants for the waveform capture store
`ifndef WAVE_STORE_CONSTS_VH
`define WAVE_STORE_CONSTS_VH

// raw region: 10-bit words plus the defect flag above them
`define RAW_DEPTH      1024
`define RAW_AW         10
`define RAW_W          11
`define FLAG_BIT       10
`define PTR_W          11
`define PTR_ONE        11'h001

// target geometry
`define SCANS          512
`define SCAN_W         9
`define SCAN_LAST      9'h1FF
`define Y_W            9
`define FAST_W         8

// per-scan capacity
`define CNT_W          5
`define CAP_NORMAL     5'h1E
`define CAP_FAST       5'h0E

// processed region: 16-bit words, two 512-word halves
`define PROC_DEPTH     1024
`define PROC_W         16
`define PROC_HALF      10'h200

// defect list
`define DFL_DEPTH      16
`define DFL_AW         4
`define DFL_TOP        4'hF
`define DFL_W          10

// read-out commands
`define CMD_W          3
`define CMD_READ_Y     3'h0
`define CMD_DUMP       3'h1
`define CMD_PTR        3'h2
`define CMD_CNT        3'h3
`define CMD_PROC       3'h4
`define CMD_DFL        3'h5

// quiet cycles before a capture left without words is closed
`define IDLE_W         11
`define IDLE_MAX       11'h400
`define IDLE_ONE       11'h001

`endif

/* verilog/waveform_capture_store.v */
// waveform capture store: target readout capture, count, defect flagging and processing
`timescale 1ns/1ns
`include "wave_store_consts.vh"

// How it works
// - raw region 10-bit words, processed 16-bit words
// - store detected points during digitize, up to the per-scan cap
// - start anywhere, stop when beam returns
// - store top-to-bottom, scans left to right
// - normal read undoes raw array wrap
// - raw dump returns data exactly as stored
// - count array holds values per scan
// - counts converted into pointers into vertical array
// - defect list above pointers, filled top down
// - 512..1023 horizontal, then 0..511 vertical defects
// - matching raw word gets bit 10 set
// - processed region: 1K edges or two halves
// - each processed array 512 points, left-right
// - edges, centre mean, repetitive mean of centres
// - edge arrays and average arrays never coexist
// - fast variant 256x256, at most 14 per scan
// - fast data normalised: y doubled, odd scans empty
// - pairs kept, values complemented, 511 is top
// - up to 30 values per vertical scan
module waveform_capture_store (
  // clock and reset
  input  wire                 i_clk,
  input  wire                 i_nrst,
  // capture control
  input  wire                 i_start,
  input  wire                 i_fast,
  input  wire                 i_defect_en,
  input  wire                 i_avg_mode,
  input  wire                 i_avg_restart,
  // target readout stream: mark=1 opens a scan with x in data
  input  wire                 i_fe_valid,
  input  wire                 i_fe_mark,
  input  wire [`Y_W-1:0]      i_fe_data,
  output reg                  o_fe_ready,
  // defect list loading
  input  wire                 i_dfl_clear,
  input  wire                 i_dfl_wr,
  input  wire [`DFL_W-1:0]    i_dfl_data,
  // read-out port
  input  wire                 i_rd_req,
  input  wire [`CMD_W-1:0]    i_rd_cmd,
  input  wire [`RAW_AW-1:0]   i_rd_addr,
  output reg                  o_rd_valid,
  output reg  [`PROC_W-1:0]   o_rd_data,
  // status
  output reg                  o_busy,
  output reg                  o_done,
  output reg  [`PTR_W-1:0]    o_raw_count
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ARM  = 3'h1;
  localparam [2:0] ST_CAP  = 3'h2;
  localparam [2:0] ST_PROC = 3'h3;

  // storage
  reg [`RAW_W-1:0]   raw_mem  [0:`RAW_DEPTH-1];
  reg [`CNT_W-1:0]   cnt_mem  [0:`SCANS-1];
  reg [`PTR_W-1:0]   ptr_mem  [0:`SCANS-1];
  reg [`PROC_W-1:0]  proc_mem [0:`PROC_DEPTH-1];
  reg [`DFL_W-1:0]   dfl_mem  [0:`DFL_DEPTH-1];
  reg [`SCAN_W-1:0]  dfl_tag  [0:`DFL_DEPTH-1];
  reg [`DFL_DEPTH-1:0] dfl_used;

  // control state
  reg [2:0]          state;
  reg                fast;
  reg                avg_mode;
  reg                avg_first;
  reg [`SCAN_W-1:0]  start_x;
  reg [`SCAN_W-1:0]  cur_x;
  reg [`PTR_W-1:0]   wptr;
  reg [`PTR_W-1:0]   wrap_base;
  reg [`PTR_W-1:0]   acc;
  reg [`SCAN_W-1:0]  px;
  reg [`DFL_AW-1:0]  dfl_idx;
  reg [`SCAN_W-1:0]  dfl_h;
  reg [`IDLE_W-1:0]  idle_cnt;

  // two-entry buffer between readout and memory writer
  reg [`Y_W:0]       fb_data0;
  reg [`Y_W:0]       fb_data1;
  reg [1:0]          fb_cnt;
  reg [1:0]          next_fb_cnt;
  wire               fb_push = i_fe_valid & o_fe_ready;
  wire               fb_pop  = (fb_cnt != 2'h0) & ((state == ST_ARM) | (state == ST_CAP));
  wire               hd_mark = fb_data0[`Y_W];
  wire [`Y_W-1:0]    hd_data = fb_data0[`Y_W-1:0];

  // unwrap a logical index into a physical raw address
  function [`RAW_AW-1:0] phys;
    input [`PTR_W-1:0] u;
    input [`PTR_W-1:0] base;
    input [`PTR_W-1:0] total;
    reg   [`PTR_W:0]   s;
    begin
      s = {1'b0, u} + {1'b0, base};
      if (s >= {1'b0, total}) begin
        s = s - {1'b0, total};
      end
      phys = s[`RAW_AW-1:0];
    end
  endfunction

  // normalise a scan position to the 512-scan grid
  function [`SCAN_W-1:0] norm_x;
    input [`Y_W-1:0] d;
    input            f;
    begin
      norm_x = f ? {d[`FAST_W-1:0], 1'b0} : d[`SCAN_W-1:0];
    end
  endfunction

  // complemented, normalised vertical value
  wire [`Y_W-1:0]    y_norm = fast ? {~hd_data[`FAST_W-1:0], 1'b0} : ~hd_data;
  wire [`SCAN_W-1:0] mark_x = norm_x(hd_data, fast);
  wire [`CNT_W-1:0]  cap    = fast ? `CAP_FAST : `CAP_NORMAL;

  // defect match against every list entry, done in parallel
  wire [`DFL_DEPTH-1:0] dfl_hit;
  genvar g;
  generate
    for (g = 0; g < `DFL_DEPTH; g = g + 1) begin : g_dfl
      assign dfl_hit[g] = dfl_used[g] & ~dfl_mem[g][`SCAN_W] &
                          (dfl_mem[g][`Y_W-1:0] == y_norm) & (dfl_tag[g] == cur_x);
    end
  endgenerate
  wire flag = i_defect_en & (|dfl_hit);

  // processing pass: first and last entry of scan px
  wire [`CNT_W-1:0]  pc    = cnt_mem[px];
  wire [`PTR_W-1:0]  last  = acc + {{(`PTR_W-`CNT_W){1'b0}}, pc} - `PTR_ONE;
  wire [`Y_W-1:0]    top_v = (pc == {`CNT_W{1'b0}}) ? {`Y_W{1'b0}} :
                             raw_mem[phys(acc, wrap_base, wptr)][`Y_W-1:0];
  wire [`Y_W-1:0]    bot_v = (pc == {`CNT_W{1'b0}}) ? {`Y_W{1'b0}} :
                             raw_mem[phys(last, wrap_base, wptr)][`Y_W-1:0];
  wire [`Y_W:0]      ctr_s = {1'b0, top_v} + {1'b0, bot_v};
  wire [`PROC_W-1:0] ctr   = {{(`PROC_W-`Y_W){1'b0}}, ctr_s[`Y_W:1]};
  wire [`PROC_W:0]   mean_s = {1'b0, proc_mem[{1'b1, px}]} + {1'b0, ctr};

  // buffer occupancy and registered ready
  always @* begin
    next_fb_cnt = fb_cnt;
    if (fb_push & ~fb_pop) begin
      next_fb_cnt = fb_cnt + 2'h1;
    end else if (fb_pop & ~fb_push) begin
      next_fb_cnt = fb_cnt - 2'h1;
    end
  end

  always @(posedge i_clk) begin
    if (!i_nrst) begin
      fb_cnt     <= 2'h0;
      o_fe_ready <= 1'b0;
      fb_data0   <= {(`Y_W+1){1'b0}};
      fb_data1   <= {(`Y_W+1){1'b0}};
    end else begin
      fb_cnt     <= next_fb_cnt;
      o_fe_ready <= (next_fb_cnt != 2'h2);
      // a stall in the writer holds words here rather than losing them
      if (fb_pop) begin
        fb_data0 <= (fb_push & (fb_cnt == 2'h1)) ? {i_fe_mark, i_fe_data} : fb_data1;
      end else if (fb_push & (fb_cnt == 2'h0)) begin
        fb_data0 <= {i_fe_mark, i_fe_data};
      end
      if (fb_push & (next_fb_cnt == 2'h2)) begin
        fb_data1 <= {i_fe_mark, i_fe_data};
      end
    end
  end

  // defect list: written from the top address downward
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      dfl_used <= {`DFL_DEPTH{1'b0}};
      dfl_idx  <= `DFL_TOP;
      dfl_h    <= {`SCAN_W{1'b0}};
    end else if (i_dfl_clear) begin
      dfl_used <= {`DFL_DEPTH{1'b0}};
      dfl_idx  <= `DFL_TOP;
      dfl_h    <= {`SCAN_W{1'b0}};
    end else if (i_dfl_wr & ~dfl_used[dfl_idx]) begin
      dfl_mem[dfl_idx]  <= i_dfl_data;
      dfl_used[dfl_idx] <= 1'b1;
      dfl_idx           <= dfl_idx - 4'h1;
      if (i_dfl_data[`SCAN_W]) begin
        dfl_h            <= i_dfl_data[`SCAN_W-1:0];
        dfl_tag[dfl_idx] <= i_dfl_data[`SCAN_W-1:0];
      end else begin
        dfl_tag[dfl_idx] <= dfl_h;
      end
    end
  end

  // capture and processing sequencer
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      state     <= ST_IDLE;
      fast      <= 1'b0;
      avg_mode  <= 1'b0;
      avg_first <= 1'b1;
      start_x   <= {`SCAN_W{1'b0}};
      cur_x     <= {`SCAN_W{1'b0}};
      wptr      <= {`PTR_W{1'b0}};
      wrap_base <= {`PTR_W{1'b0}};
      acc       <= {`PTR_W{1'b0}};
      px        <= {`SCAN_W{1'b0}};
      idle_cnt  <= {`IDLE_W{1'b0}};
      o_busy    <= 1'b0;
      o_done    <= 1'b0;
      o_raw_count <= {`PTR_W{1'b0}};
    end else begin
      o_done <= 1'b0;
      // counts quiet cycles so a frame cut short still ends
      if (fb_pop | ((state != ST_ARM) & (state != ST_CAP))) begin
        idle_cnt <= {`IDLE_W{1'b0}};
      end else begin
        idle_cnt <= idle_cnt + `IDLE_ONE;
      end
      case (state)
        ST_IDLE: begin
          if (i_start) begin
            fast      <= i_fast;
            avg_mode  <= i_avg_mode;
            avg_first <= i_avg_restart | (avg_mode != i_avg_mode);
            wptr      <= {`PTR_W{1'b0}};
            wrap_base <= {`PTR_W{1'b0}};
            o_busy    <= 1'b1;
            state     <= ST_ARM;
          end
        end
        ST_ARM: begin
          // detections before the first scan start are discarded
          if (fb_pop & hd_mark) begin
            start_x <= mark_x;
            cur_x   <= mark_x;
            cnt_mem[mark_x] <= {`CNT_W{1'b0}};
            if (fast) begin
              cnt_mem[mark_x + 9'h001] <= {`CNT_W{1'b0}};
            end
            state <= ST_CAP;
          end else if (idle_cnt == `IDLE_MAX) begin
            // no scan start came: give up rather than stay busy
            o_raw_count <= {`PTR_W{1'b0}};
            o_busy      <= 1'b0;
            o_done      <= 1'b1;
            state       <= ST_IDLE;
          end
        end
        ST_CAP: begin
          if (fb_pop & hd_mark) begin
            if (mark_x == start_x) begin
              o_raw_count <= wptr;
              acc   <= {`PTR_W{1'b0}};
              px    <= {`SCAN_W{1'b0}};
              state <= ST_PROC;
            end else begin
              cur_x <= mark_x;
              cnt_mem[mark_x] <= {`CNT_W{1'b0}};
              if (fast) begin
                cnt_mem[mark_x + 9'h001] <= {`CNT_W{1'b0}};
              end
              if (mark_x == {`SCAN_W{1'b0}}) begin
                wrap_base <= wptr;
              end
            end
          end else if (fb_pop) begin
            // words past the per-scan cap or a full array are dropped
            if ((cnt_mem[cur_x] < cap) && (wptr < `RAW_DEPTH)) begin
              raw_mem[wptr[`RAW_AW-1:0]] <= {flag, 1'b0, y_norm};
              wptr <= wptr + `PTR_ONE;
              cnt_mem[cur_x] <= cnt_mem[cur_x] + 5'h01;
            end
          end else if (idle_cnt == `IDLE_MAX) begin
            // cut frame: keep what came and process it; scans never seen keep old counts
            o_raw_count <= wptr;
            acc   <= {`PTR_W{1'b0}};
            px    <= {`SCAN_W{1'b0}};
            state <= ST_PROC;
          end
        end
        ST_PROC: begin
          ptr_mem[px] <= acc;
          acc <= acc + {{(`PTR_W-`CNT_W){1'b0}}, pc};
          if (avg_mode) begin
            proc_mem[{1'b0, px}] <= ctr;
            proc_mem[{1'b1, px}] <= avg_first ? ctr : mean_s[`PROC_W:1];
          end else begin
            proc_mem[{1'b0, px}] <= {{(`PROC_W-`Y_W){1'b0}}, top_v};
            proc_mem[{1'b1, px}] <= {{(`PROC_W-`Y_W){1'b0}}, bot_v};
          end
          px <= px + 9'h001;
          if (px == `SCAN_LAST) begin
            avg_first <= 1'b0;
            o_busy    <= 1'b0;
            o_done    <= 1'b1;
            state     <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // read-out: one cycle from request to data
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= {`PROC_W{1'b0}};
    end else begin
      o_rd_valid <= i_rd_req;
      if (i_rd_req) begin
        if (i_rd_cmd == `CMD_READ_Y) begin
          if ({1'b0, i_rd_addr} < o_raw_count) begin
            o_rd_data <= {{(`PROC_W-`RAW_W){1'b0}},
                          raw_mem[phys({1'b0, i_rd_addr}, wrap_base, o_raw_count)]};
          end else begin
            o_rd_data <= {`PROC_W{1'b0}};
          end
        end else if (i_rd_cmd == `CMD_DUMP) begin
          o_rd_data <= {{(`PROC_W-`RAW_W){1'b0}}, raw_mem[i_rd_addr]};
        end else if (i_rd_cmd == `CMD_PTR) begin
          o_rd_data <= {{(`PROC_W-`PTR_W){1'b0}}, ptr_mem[i_rd_addr[`SCAN_W-1:0]]};
        end else if (i_rd_cmd == `CMD_CNT) begin
          o_rd_data <= {{(`PROC_W-`CNT_W){1'b0}}, cnt_mem[i_rd_addr[`SCAN_W-1:0]]};
        end else if (i_rd_cmd == `CMD_PROC) begin
          o_rd_data <= proc_mem[i_rd_addr];
        end else if (i_rd_cmd == `CMD_DFL) begin
          o_rd_data <= {{(`PROC_W-`DFL_W){1'b0}}, dfl_mem[i_rd_addr[`DFL_AW-1:0]]};
        end else begin
          o_rd_data <= {`PROC_W{1'b0}};
        end
      end
    end
  end

endmodule
